// >>> rtl/fpc_ctrl.sv
// Host controller that drives an asynchronous parallel flash through its pins:
// command writes, reads, high-voltage group protection and verify, status reads,
// extended protection by command, and hardware reset pulses.
// Assumes the board turns a9_hv_o and reset_hv_o into the elevated voltage level.
`timescale 1ns/100ps
`default_nettype none
module fpc_ctrl #(
  parameter int PROT_CYC = fpc_pkg::PROT_PULSE_CYC,
  parameter int EXT_CYC = fpc_pkg::EXT_PROT_CYC,
  parameter int RETRY_MAX = fpc_pkg::EXT_RETRY_MAX
) (
  input wire logic ref_clk_i,                         // 125 MHz clock.
  input wire logic nrst_i,                            // Asynchronous reset, active low.
  input wire logic req_i,                             // Request, taken when idle_o.
  input wire fpc_pkg::fpc_op_t op_i,                  // Operation.
  input wire logic [fpc_pkg::ADDR_W-1:0] addr_i,      // Address for write and read.
  input wire logic [fpc_pkg::DATA_W-1:0] wdata_i,     // Write data.
  input wire logic [fpc_pkg::GROUP_W-1:0] group_i,    // Sector group address.
  input wire logic temp_unprotect_i,                  // Hold reset pin elevated.
  input wire logic boot_lock_i,                       // Lock outer boot sectors.
  output logic idle_o,                                // Ready for a request.
  output logic done_o,                                // One-cycle completion pulse.
  output logic fail_o,                                // Last request refused or failed.
  output logic [fpc_pkg::DATA_W-1:0] rdata_o,         // Last read data.
  output logic flash_ready_o,                         // Qualified done indicator.
  output logic ce_n_o,                                // Chip select, active low.
  output logic we_n_o,                                // Write strobe, active low.
  output logic oe_n_o,                                // Output gate, active low.
  output logic [fpc_pkg::ADDR_W-1:0] addr_o,          // Address pins.
  output logic [fpc_pkg::DATA_W-1:0] dq_o,            // Data pins out.
  output logic dq_oe_o,                               // Data pins driven.
  input wire logic [fpc_pkg::DATA_W-1:0] dq_i,        // Data pins in.
  output logic a9_hv_o,                               // Elevated level on line nine.
  output logic rst_n_o,                               // Reset pin, active low.
  output logic reset_hv_o,                            // Elevated level on reset pin.
  output logic write_protect_accel_pin_o,             // Boot protect pin, low locks.
  input wire logic done_indicator_i                   // Device done indicator.
);
  import fpc_pkg::*;

  fpc_state_t state_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] dq_ff, rdata_ff;
  logic ce_n_ff, we_n_ff, oe_n_ff, dq_oe_ff, hv_ff, wr_ff, rst_n_ff, rst_hv_ff;
  logic done_ff, fail_ff, ext_ff, wp_ff, id_active_ff, tmr_load_ff, tmr_exp;
  logic [2:0] id_bank_ff;
  logic [1:0] ext_step_ff;
  logic [7:0] retry_ff;
  logic [TMR_W-1:0] tmr_val_ff;

  // Next-cycle descriptor.
  logic go, fin, nwr, nhv, id_clash;
  logic [1:0] nxt_step;
  logic [ADDR_W-1:0] naddr, grp_addr;
  logic [DATA_W-1:0] ndata;

  fpc_timer #(.W(TMR_W)) u_timer (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .load_i(tmr_load_ff),
    .value_i(tmr_val_ff),
    .expired_o(tmr_exp)
  );

  assign grp_addr = {group_i, PROT_LOW_ADDR};
  assign id_clash = (wdata_i[7:0] == CMD_AUTOSEL) && id_active_ff &&
                    (addr_i[21:19] != id_bank_ff);

  always_comb begin
    go = 1'b0;
    fin = 1'b0;
    nwr = 1'b0;
    nhv = 1'b0;
    naddr = addr_i;
    ndata = wdata_i;
    nxt_step = ext_step_ff;
    if (state_ff == S_IDLE && req_i) begin
      unique case (op_i)
        FPC_OP_WRITE: begin
          go = !id_clash;
          nwr = 1'b1;
        end
        FPC_OP_READ: go = 1'b1;
        FPC_OP_PROTECT: begin
          go = 1'b1;
          nwr = 1'b1;
          nhv = 1'b1;
          naddr = grp_addr;
        end
        FPC_OP_VERIFY: begin
          go = 1'b1;
          nhv = 1'b1;
          naddr = grp_addr;
        end
        FPC_OP_STATUS: begin
          go = 1'b1;
          naddr = grp_addr;
        end
        FPC_OP_EXTPROT: begin
          go = 1'b1;
          nwr = 1'b1;
          ndata = CMD_EXT_PROT;
          naddr = grp_addr;
          nxt_step = 2'd0;
        end
        FPC_OP_RESET: go = 1'b0;
        default: go = 1'b0;
      endcase
    end else if (state_ff == S_EXTWAIT && tmr_exp) begin
      go = 1'b1;
      nwr = 1'b1;
      ndata = CMD_EXT_VERIFY;
      naddr = addr_ff;
      nxt_step = 2'd2;
    end else if (state_ff == S_RECOV) begin
      naddr = addr_ff;
      if (!ext_ff) begin
        fin = 1'b1;
      end else begin
        unique case (ext_step_ff)
          2'd0: begin
            go = 1'b1;
            nwr = 1'b1;
            ndata = CMD_EXT_PROT;
            nxt_step = 2'd1;
          end
          2'd1: fin = 1'b0;
          2'd2: begin
            go = 1'b1;
            nxt_step = 2'd3;
          end
          2'd3: begin
            // A zero on bit 0 means the group did not take; protect again unless RETRY_MAX retries are used up.
            go = !rdata_ff[0] && (retry_ff < 8'(RETRY_MAX));
            fin = !go;
            nwr = 1'b1;
            ndata = CMD_EXT_PROT;
            nxt_step = 2'd1;
          end
        endcase
      end
    end
  end

  // Bus sequencer: every cycle opens with select low, then one strobe; a protect pulse drops both write strobe and output gate.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= S_IDLE;
      addr_ff <= '0;
      dq_ff <= '0;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      dq_oe_ff <= 1'b0;
      hv_ff <= 1'b0;
      wr_ff <= 1'b0;
      rst_n_ff <= 1'b1;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      ext_ff <= 1'b0;
      ext_step_ff <= 2'd0;
      retry_ff <= 8'h00;
      tmr_load_ff <= 1'b0;
      tmr_val_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      tmr_load_ff <= 1'b0;
      if (go) begin
        state_ff <= S_SETUP;
        addr_ff <= naddr;
        dq_ff <= ndata;
        wr_ff <= nwr;
        hv_ff <= nhv;
        ce_n_ff <= 1'b0;
        we_n_ff <= 1'b1;
        oe_n_ff <= 1'b1;
        dq_oe_ff <= nwr;
        ext_step_ff <= nxt_step;
        if (state_ff == S_RECOV && ext_step_ff == 2'd3) begin
          retry_ff <= retry_ff + 8'h01;
        end
      end
      unique case (state_ff)
        S_IDLE: begin
          if (req_i) begin
            fail_ff <= 1'b0;
            ext_ff <= (op_i == FPC_OP_EXTPROT);
            retry_ff <= 8'h00;
            if (op_i == FPC_OP_RESET) begin
              state_ff <= S_RST;
              rst_n_ff <= 1'b0;
              tmr_load_ff <= 1'b1;
              tmr_val_ff <= TMR_W'(RESET_PULSE_MIN_CYC);
            end else if (!go) begin
              done_ff <= 1'b1;
              fail_ff <= 1'b1;
            end
          end
        end
        S_SETUP: begin
          state_ff <= S_STROBE;
          we_n_ff <= !wr_ff;
          oe_n_ff <= wr_ff && !hv_ff;
          tmr_load_ff <= 1'b1;
          if (wr_ff && hv_ff) begin
            tmr_val_ff <= TMR_W'(PROT_CYC);
          end else if (wr_ff) begin
            tmr_val_ff <= TMR_W'(WE_LOW_CYC);
          end else begin
            tmr_val_ff <= TMR_W'(READ_ACC_CYC);
          end
        end
        S_STROBE: begin
          if (tmr_exp) begin
            state_ff <= S_RECOV;
            we_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
          end
        end
        S_RECOV: begin
          if (!go) begin
            ce_n_ff <= 1'b1;
            dq_oe_ff <= 1'b0;
            hv_ff <= 1'b0;
            if (fin) begin
              state_ff <= S_IDLE;
              done_ff <= 1'b1;
              ext_ff <= 1'b0;
              fail_ff <= ext_ff && !rdata_ff[0];
            end else begin
              state_ff <= S_EXTWAIT;
              tmr_load_ff <= 1'b1;
              tmr_val_ff <= TMR_W'(EXT_CYC);
            end
          end
        end
        S_EXTWAIT: state_ff <= go ? S_SETUP : S_EXTWAIT;
        S_RST: begin
          if (tmr_exp) begin
            state_ff <= S_RWAIT;
            rst_n_ff <= 1'b1;
            tmr_load_ff <= 1'b1;
            tmr_val_ff <= TMR_W'(RESET_RELEASE_WAIT_CYC);
          end
        end
        S_RWAIT: begin
          if (tmr_exp) begin
            state_ff <= S_IDLE;
            done_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= '0;
    end else if (state_ff == S_STROBE && tmr_exp && !wr_ff) begin
      rdata_ff <= dq_i;
    end
  end

  // Identification mode tracking; a second bank is refused until read mode is restored.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      id_active_ff <= 1'b0;
      id_bank_ff <= 3'h0;
    end else if (state_ff == S_IDLE && req_i && op_i == FPC_OP_RESET) begin
      id_active_ff <= 1'b0;
    end else if (state_ff == S_IDLE && go && op_i == FPC_OP_WRITE) begin
      if (wdata_i[7:0] == CMD_AUTOSEL) begin
        id_active_ff <= 1'b1;
        id_bank_ff <= addr_i[21:19];
      end else if (wdata_i[7:0] == CMD_READ_RESET) begin
        id_active_ff <= 1'b0;
      end
    end
  end

  // The reset pin stays elevated across the whole extended sequence.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_hv_ff <= 1'b0;
      wp_ff <= 1'b1;
    end else begin
      rst_hv_ff <= temp_unprotect_i ||
                   (state_ff == S_IDLE && req_i && op_i == FPC_OP_EXTPROT) ||
                   (ext_ff && !fin);
      wp_ff <= !boot_lock_i;
    end
  end

  assign idle_o = (state_ff == S_IDLE);
  assign done_o = done_ff;
  assign fail_o = fail_ff;
  assign rdata_o = rdata_ff;
  assign flash_ready_o = done_indicator_i && rst_n_ff;
  assign ce_n_o = ce_n_ff;
  assign we_n_o = we_n_ff;
  assign oe_n_o = oe_n_ff;
  assign addr_o = addr_ff;
  assign dq_o = dq_ff;
  assign dq_oe_o = dq_oe_ff && rst_n_ff;
  assign a9_hv_o = hv_ff;
  assign rst_n_o = rst_n_ff;
  assign reset_hv_o = rst_hv_ff;
  assign write_protect_accel_pin_o = wp_ff;

  // Helper counters for pulse-length checks.
  logic [TMR_W-1:0] we_low_cnt_ff, rst_low_cnt_ff;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      we_low_cnt_ff <= '0;
      rst_low_cnt_ff <= '0;
    end else begin
      we_low_cnt_ff <= we_n_ff ? '0 : we_low_cnt_ff + 1'b1;
      rst_low_cnt_ff <= rst_n_ff ? '0 : rst_low_cnt_ff + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  wr_strobe_a: assert property ((!we_n_o && !a9_hv_o) |-> (!ce_n_o && oe_n_o))
    else $error("write strobe low without select low and gate high");
  we_len_a: assert property (
      ($rose(we_n_o) && !a9_hv_o) |-> ($past(we_low_cnt_ff) >= WE_LOW_CYC))
    else $error("write strobe pulse too short");
  wr_hold_a: assert property (
      (!we_n_o && !$past(we_n_o)) |-> ($stable(addr_o) && $stable(dq_o)))
    else $error("address or data moved during write strobe");
  wr_data_a: assert property (
      $rose(we_n_o) |-> (!ce_n_o && (dq_oe_o || a9_hv_o)))
    else $error("data or select dropped at strobe rise");
  prot_pins_a: assert property (
      (a9_hv_o && !we_n_o) |-> (!oe_n_o && !ce_n_o && addr_o[11:0] == PROT_LOW_ADDR))
    else $error("protect pulse with wrong control or low address");
  rst_len_a: assert property (
      $rose(rst_n_o) |-> ($past(rst_low_cnt_ff) >= RESET_PULSE_MIN_CYC))
    else $error("reset pulse shorter than minimum");
  rst_quiet_a: assert property (
      !rst_n_o |-> (!dq_oe_o && !flash_ready_o && we_n_o))
    else $error("activity or ready during reset pulse");
  ext_hv_a: assert property (
      (ext_ff && !we_n_o) |-> reset_hv_o)
    else $error("extended protect write without elevated reset");
  ext_end_a: assert property (
      $fell(ext_ff) |-> (reset_hv_o == $past(temp_unprotect_i)))
    else $error("reset pin not returned at end of extended protect");
endmodule : fpc_ctrl
`default_nettype wire

// >>> rtl/fpc_pkg.sv
// Constants and types for the host-side flash command and protection controller.
// Assumes a 125 MHz reference clock; all pin timings are derived from it here.
package fpc_pkg;

  localparam int CLK_NS = 8;

  // Pin timing in nanoseconds; least times round up to whole cycles.
  localparam int WE_LOW_NS = 35;
  localparam int READ_ACC_NS = 90;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_RELEASE_WAIT_NS = 200;
  localparam int PROT_PULSE_NS = 100000;
  localparam int EXT_PROT_TYP_NS = 250000;

  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_ACC_CYC = (READ_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_RELEASE_WAIT_CYC = (RESET_RELEASE_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROT_PULSE_CYC = (PROT_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_PROT_CYC = (EXT_PROT_TYP_NS + CLK_NS - 1) / CLK_NS;

  localparam int TMR_W = 16;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int GROUP_W = 10;
  localparam int EXT_RETRY_MAX = 25;

  // Low address bits 11..0 for protect, verify and status reads: A1 high, A6/A3/A2/A0 low.
  localparam logic [11:0] PROT_LOW_ADDR = 12'h002;

  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_READ_RESET = 8'hF0;
  localparam logic [15:0] CMD_EXT_PROT = 16'h0060;
  localparam logic [15:0] CMD_EXT_VERIFY = 16'h0040;

  typedef enum logic [2:0] {
    FPC_OP_WRITE = 3'h0,
    FPC_OP_READ = 3'h1,
    FPC_OP_PROTECT = 3'h2,
    FPC_OP_VERIFY = 3'h3,
    FPC_OP_STATUS = 3'h4,
    FPC_OP_EXTPROT = 3'h5,
    FPC_OP_RESET = 3'h6
  } fpc_op_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_SETUP = 7'h02,
    S_STROBE = 7'h04,
    S_RECOV = 7'h08,
    S_EXTWAIT = 7'h10,
    S_RST = 7'h20,
    S_RWAIT = 7'h40
  } fpc_state_t;

endpackage : fpc_pkg

// >>> rtl/fpc_timer.sv
// Down-counting cycle timer used to stretch strobe and reset pulses.
// Assumes the loader pulses load_i for one cycle and waits for expired_o.
`timescale 1ns/100ps
`default_nettype none
module fpc_timer #(
  parameter int W = 16
) (
  input wire logic ref_clk_i,      // System clock.
  input wire logic nrst_i,         // Asynchronous reset, active low.
  input wire logic load_i,         // Start pulse.
  input wire logic [W-1:0] value_i, // Cycles to count.
  output logic expired_o           // High once the count has run out.
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= {W{1'b0}};
    end else if (load_i) begin
      cnt_ff <= value_i;
    end else if (cnt_ff != {W{1'b0}}) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // A load in flight hides the stale zero so no strobe ends early.
  assign expired_o = (cnt_ff == {W{1'b0}}) && !load_i;
endmodule : fpc_timer
`default_nettype wire

// >>> test/fpc_flash_model.sv
// Behavioural model of the parallel flash that the controller drives.
// Assumes its pins are wired straight to the controller; it has no clock.
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_model #(
  parameter logic [15:0] ID_CODE = 16'h0123 // Arbitrary identification value.
) (
  input wire logic ce_n_i,         // Chip select.
  input wire logic we_n_i,         // Write strobe.
  input wire logic oe_n_i,         // Output gate.
  input wire logic [21:0] addr_i,  // Address pins.
  input wire logic [15:0] dq_i,    // Data from host.
  input wire logic a9_hv_i,        // Elevated level on line nine.
  input wire logic rst_n_i,        // Reset pin.
  input wire logic reset_hv_i,     // Elevated level on reset pin.
  output logic [15:0] dq_o,        // Data to host.
  output logic done_indicator_o    // Done indicator.
);
  logic [1023:0] prot = '0;
  logic [21:0] lat_addr = '0;
  logic [15:0] lat_data = '0;
  logic [15:0] val;
  logic [15:0] last = '0;
  logic [9:0] pulse_grp = '0;
  logic [2:0] id_bank = '0;
  logic cmd_act = 1'b0;
  logic pulse_ok = 1'b0;
  logic in_ident = 1'b0;
  logic ver_mode = 1'b0;
  logic ext_cnt = 1'b0;
  logic junk = 1'b0;
  logic rd_en;

  assign rd_en = !ce_n_i && !oe_n_i && we_n_i && rst_n_i;
  always_comb begin
    val = addr_i[15:0] ^ 16'h5A3C;
    if (a9_hv_i || ver_mode || (in_ident && addr_i[21:19] == id_bank)) begin
      val = {15'h0, prot[addr_i[21:12]]};
      if (addr_i[6] || addr_i[3:0] != 4'h2) begin
        val = ID_CODE;
      end
    end
  end
  // A released bus shows the inverse of its last value so stale data never passes.
  always @* begin
    if (rd_en) begin
      last = val;
    end
  end
  assign dq_o = rd_en ? val : ~last;

  // Strobe and gate fall in one time step, in either order, so the gate starts a pulse too.
  always @(negedge we_n_i or negedge ce_n_i or negedge oe_n_i) begin
    if (!we_n_i && !ce_n_i && oe_n_i) begin
      lat_addr = addr_i;
      cmd_act = 1'b1;
    end
    if (!we_n_i && !ce_n_i && !oe_n_i && a9_hv_i) begin
      pulse_grp = addr_i[21:12];
      pulse_ok = (addr_i[11:0] == 12'h002);
      cmd_act = 1'b0;
    end
  end
  always @(addr_i) begin
    if (!we_n_i) begin
      pulse_ok = 1'b0;
    end
  end
  always @(posedge we_n_i or posedge ce_n_i) begin
    if (pulse_ok) begin
      prot[pulse_grp] = 1'b1;
    end
    pulse_ok = 1'b0;
    if (cmd_act) begin
      cmd_act = 1'b0;
      lat_data = dq_i;
      case (dq_i[7:0])
        8'hF0: begin
          in_ident = 1'b0;
          ver_mode = 1'b0;
        end
        8'h90: begin
          in_ident = 1'b1;
          id_bank = lat_addr[21:19];
        end
        8'h60: begin
          if (reset_hv_i && ext_cnt) begin
            prot[lat_addr[21:12]] = 1'b1;
          end
          ext_cnt = reset_hv_i;
        end
        8'h40: ver_mode = reset_hv_i;
        default: ;
      endcase
    end
  end
  always @(negedge rst_n_i or negedge reset_hv_i) begin
    in_ident = 1'b0;
    ver_mode = 1'b0;
    ext_cnt = 1'b0;
    // A write or pulse cut by reset is dropped; its target keeps its old content.
    cmd_act = 1'b0;
    pulse_ok = 1'b0;
  end
  // The done indicator carries no meaning during reset, so it toggles then.
  always #10 junk = ~junk;
  assign done_indicator_o = rst_n_i ? 1'b1 : junk;
endmodule : fpc_flash_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the flash command and protection controller.
// Assumes the flash model stands on the pins; long counts are shortened.
`timescale 1ns/100ps
`default_nettype none
`define CHK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value %s expected %0h seen %0h", name, exp, got); end end
module testbench;
  import fpc_pkg::*;
  logic ref_clk_i, nrst_i, req_i, temp_unprotect_i, boot_lock_i;
  fpc_op_t op_i;
  logic [21:0] addr_i;
  logic [15:0] wdata_i, rdata_o, dq_o, dq_i;
  logic [9:0] group_i;
  logic idle_o, done_o, fail_o, flash_ready_o, ce_n_o, we_n_o, oe_n_o, dq_oe_o;
  logic a9_hv_o, rst_n_o, reset_hv_o, wp_o, done_ind;
  logic [21:0] addr_o;
  int err_count = 0, n_tests = 0, cyc = 0, low_cyc = 0, bad_rst = 0, bad_we = 0, hv_seen = 0;

  fpc_ctrl #(.PROT_CYC(20), .EXT_CYC(20), .RETRY_MAX(3)) DUT (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .req_i(req_i), .op_i(op_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .group_i(group_i), .temp_unprotect_i(temp_unprotect_i), .boot_lock_i(boot_lock_i),
    .idle_o(idle_o), .done_o(done_o), .fail_o(fail_o), .rdata_o(rdata_o),
    .flash_ready_o(flash_ready_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o),
    .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i), .a9_hv_o(a9_hv_o),
    .rst_n_o(rst_n_o), .reset_hv_o(reset_hv_o), .write_protect_accel_pin_o(wp_o),
    .done_indicator_i(done_ind));
  fpc_flash_model u_flash (.ce_n_i(ce_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o),
    .addr_i(addr_o), .dq_i(dq_o), .a9_hv_i(a9_hv_o), .rst_n_i(rst_n_o),
    .reset_hv_i(reset_hv_o), .dq_o(dq_i), .done_indicator_o(done_ind));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // Pin watch: strobe legality, reset pulse length and the qualified done flag.
  always @(negedge ref_clk_i) begin
    if (we_n_o === 1'b0 && (ce_n_o !== 1'b0 || (oe_n_o !== 1'b1 && a9_hv_o !== 1'b1))) begin
      bad_we++;
    end
    if (reset_hv_o === 1'b1) begin
      hv_seen = 1;
    end
    if (nrst_i && rst_n_o === 1'b0) begin
      low_cyc++;
      if (flash_ready_o !== 1'b0 || dq_oe_o !== 1'b0) begin
        bad_rst++;
      end
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic run(input fpc_op_t op, input logic [21:0] a, input logic [15:0] d,
                     input logic [9:0] g);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    req_i <= 1'b1;
    op_i <= op;
    addr_i <= a;
    wdata_i <= d;
    group_i <= g;
    @(negedge ref_clk_i);
    while (idle_o !== 1'b1 && n < 2000) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 3000);
    `CHK("done pulse", 1'b1, done_o)
  endtask : run

  task automatic t_write();
    run(FPC_OP_WRITE, 22'h2A5555, 16'h00AA, 10'h000);
    `CHK("latched address", 22'h2A5555, u_flash.lat_addr)
    `CHK("latched data", 16'h00AA, u_flash.lat_data)
    `CHK("write fail", 1'b0, fail_o)
    run(FPC_OP_READ, 22'h012345, 16'h0000, 10'h000);
    `CHK("array read", 16'h2345 ^ 16'h5A3C, rdata_o)
  endtask : t_write

  task automatic t_protect();
    run(FPC_OP_VERIFY, 22'h0, 16'h0, 10'h005);
    `CHK("fresh group", 1'b0, rdata_o[0])
    run(FPC_OP_PROTECT, 22'h0, 16'h0, 10'h005);
    run(FPC_OP_VERIFY, 22'h0, 16'h0, 10'h005);
    `CHK("protected group", 1'b1, rdata_o[0])
    run(FPC_OP_VERIFY, 22'h0, 16'h0, 10'h006);
    `CHK("neighbour group", 1'b0, rdata_o[0])
  endtask : t_protect

  task automatic t_ident();
    run(FPC_OP_WRITE, 22'h000555, 16'h0090, 10'h000);
    run(FPC_OP_STATUS, 22'h0, 16'h0, 10'h005);
    `CHK("status protected", 1'b1, rdata_o[0])
    run(FPC_OP_WRITE, 22'h200555, 16'h0090, 10'h000);
    `CHK("clashing bank", 1'b1, fail_o)
    run(FPC_OP_WRITE, 22'h000000, 16'h00F0, 10'h000);
    run(FPC_OP_WRITE, 22'h200555, 16'h0090, 10'h000);
    `CHK("other bank", 1'b0, fail_o)
    run(FPC_OP_STATUS, 22'h0, 16'h0, 10'h200);
    `CHK("other bank status", 16'h0000, rdata_o)
    run(FPC_OP_STATUS, 22'h0, 16'h0, 10'h005);
    `CHK("old bank array", 16'h5002 ^ 16'h5A3C, rdata_o)
    run(FPC_OP_WRITE, 22'h000000, 16'h00F0, 10'h000);
  endtask : t_ident

  task automatic t_ext();
    hv_seen = 0;
    run(FPC_OP_EXTPROT, 22'h0, 16'h0, 10'h009);
    `CHK("extended fail", 1'b0, fail_o)
    `CHK("elevated reset used", 1, hv_seen)
    `CHK("elevated reset off", 1'b0, reset_hv_o)
    run(FPC_OP_VERIFY, 22'h0, 16'h0, 10'h009);
    `CHK("extended group", 1'b1, rdata_o[0])
  endtask : t_ext

  task automatic t_reset();
    low_cyc = 0;
    run(FPC_OP_RESET, 22'h0, 16'h0, 10'h000);
    `CHK("reset pulse long", 1'b1, low_cyc >= RESET_PULSE_MIN_CYC)
    `CHK("ready masked", 0, bad_rst)
    run(FPC_OP_READ, 22'h000777, 16'h0000, 10'h000);
    `CHK("read after reset", 16'h0777 ^ 16'h5A3C, rdata_o)
    `CHK("ready after reset", 1'b1, flash_ready_o)
  endtask : t_reset

  task automatic t_pins();
    `CHK("boot pin idle", 1'b1, wp_o)
    temp_unprotect_i <= 1'b1;
    boot_lock_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    `CHK("temporary unprotect", 1'b1, reset_hv_o)
    `CHK("boot lock", 1'b0, wp_o)
    temp_unprotect_i <= 1'b0;
    boot_lock_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    `CHK("unprotect off", 1'b0, reset_hv_o)
    `CHK("boot unlock", 1'b1, wp_o)
  endtask : t_pins

  initial begin
    nrst_i = 1'b0;
    req_i = 1'b0;
    op_i = FPC_OP_WRITE;
    addr_i = '0;
    wdata_i = '0;
    group_i = '0;
    temp_unprotect_i = 1'b0;
    boot_lock_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_pins();
    t_write();
    t_protect();
    t_ident();
    t_ext();
    t_reset();
    `CHK("strobe legality", 0, bad_we)
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
